// ==== src/fsw_writer.sv ====
/*
  Status and control register write unit: immediate field write, masked
  field write, single-bit clear and set, summary upkeep, record update of
  the condition register field, plus recording of exceptions from the FP
  units. Assumes the issue logic presents one instruction at a time and
  reports when all earlier FP instructions have drained.
*/
// Function
// - Field-0 writes load exception summary and overflow directly from source.
// - Field-0 writes never set exception summary through the sticky path.
// - Otherwise any exception bit rising sets the exception summary bit.
// - Field-0 writes derive bits 1 and 2 by summary, ignoring source.
// - Masked write takes source bits 32-63 under an eight-bit field mask.
// - Each selected field i takes source nibble i; others stay unchanged.
// - Masked write latency does not depend on how many fields are selected.
// - Bit clear zeroes only the indexed status bit.
// - Bit set raises the indexed status bit, and bit 0 too when that bit is a rising exception bit.
// - Bit clear and set cannot force bits 1 and 2.
// - Record variant copies the resulting status nibble to the condition field.
// - Immediate write places the nibble into the chosen field only.
// - Execute only after earlier FP work drained; hold later FP issue.
module fsw_writer
  import fsw_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  req_valid,
  output logic                       req_ready,
  input  wire fsw_op_t               req_op,
  input  wire logic                  req_record,
  input  wire logic [FLD_IDX_W-1:0]  target_field_index,
  input  wire logic [0:3]            immediate_nibble,
  input  wire logic [0:7]            field_mask,
  input  wire logic [0:SRC_W-1]      source_fp_register,
  input  wire logic [IDX_W-1:0]      target_bit_index,
  input  wire logic                  fp_drained,
  output logic                       fp_issue_hold,
  input  wire logic                  exc_valid,
  input  wire logic [0:STAT_W-1]     exc_bits,
  output logic                       done,
  output logic [0:STAT_W-1]          fp_status_control,
  output logic                       cr_update,
  output logic [0:3]                 condition_register_field
);

  // Invalid-operation summary from its cause bits
  function automatic logic vx_of(input logic [0:STAT_W-1] s);
    vx_of = |(s & VX_CAUSES);
  endfunction : vx_of

  // Enabled-exception summary from exceptions and their enables
  function automatic logic fex_of(input logic [0:STAT_W-1] s);
    logic [4:0] ex;
    logic [4:0] en;
    ex = {s[BIT_OX], s[BIT_UX], s[BIT_ZX], s[BIT_XX], vx_of(s)};
    en = {s[BIT_OE], s[BIT_UE], s[BIT_ZE], s[BIT_XE], s[BIT_VE]};
    fex_of = |(ex & en);
  endfunction : fex_of

  // True when a bit index names one of the two derived summaries
  function automatic logic is_derived(input logic [IDX_W-1:0] idx);
    is_derived = (idx == IDX_W'(BIT_FEX)) || (idx == IDX_W'(BIT_VX));
  endfunction : is_derived

  logic              accept;
  logic [0:STAT_W-1] status_r;
  logic [0:STAT_W-1] status_nxt;
  logic [0:STAT_W-1] base;
  logic [0:STAT_W-1] raw;
  logic [0:STAT_W-1] rise;
  logic              field0;
  logic              done_r;
  logic              cr_upd_r;
  logic [0:3]        cr_nib_r;

  // Acceptance waits for the FP pipe to drain; later FP issue held meanwhile
  assign req_ready     = fp_drained;
  assign accept        = req_valid && fp_drained;
  assign fp_issue_hold = req_valid;

  assign done                     = done_r;
  assign fp_status_control        = status_r;
  assign cr_update                = cr_upd_r;
  assign condition_register_field = cr_nib_r;

  // Next status: unit exceptions first, then the instruction, then summaries
  always_comb begin
    base   = status_r;
    raw    = status_r;
    field0 = 1'b0;
    // Units only report raw exception bits; summaries are ours to derive
    if (exc_valid) begin
      base = status_r | (exc_bits & EXC_MASK);
    end
    raw = base;
    if (accept) begin
      case (req_op)
        FSW_OP_FIELD_IMM: begin
          raw[FIELD_W*target_field_index +: FIELD_W] = immediate_nibble;
          field0 = (target_field_index == '0);
        end
        FSW_OP_FIELD_MASK: begin
          // One pass over all fields, so partial masks cost nothing extra
          for (int i = 0; i < NUM_FIELDS; i++) begin
            if (field_mask[i]) begin
              raw[FIELD_W*i +: FIELD_W] =
                source_fp_register[SRC_LO+FIELD_W*i +: FIELD_W];
            end
          end
          field0 = field_mask[0];
        end
        FSW_OP_BIT_CLR: begin
          if (!is_derived(target_bit_index)) begin
            raw[target_bit_index] = 1'b0;
          end
        end
        FSW_OP_BIT_SET: begin
          if (!is_derived(target_bit_index)) begin
            raw[target_bit_index] = 1'b1;
          end
        end
        default: begin
          raw = base;
        end
      endcase
    end
    rise       = raw & ~status_r & EXC_MASK;
    status_nxt = raw;
    // Direct load on field 0 beats the sticky path, even for a rising overflow
    if (field0) begin
      status_nxt[BIT_FX] = raw[BIT_FX];
    end else begin
      status_nxt[BIT_FX] = raw[BIT_FX] | (|rise);
    end
    // Source bits 1 and 2 are never taken; they are always derived
    status_nxt[BIT_VX]  = vx_of(raw);
    status_nxt[BIT_FEX] = fex_of(raw);
  end

  // Status register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_r <= STAT_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  // Completion strobe, one cycle after acceptance for every kind
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      done_r <= 1'b0;
    end else begin
      done_r <= accept;
    end
  end

  // Condition field update on the record variant only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cr_upd_r <= 1'b0;
      cr_nib_r <= NIBBLE_ZERO;
    end else begin
      cr_upd_r <= accept && req_record;
      if (accept && req_record) begin
        cr_nib_r <= status_nxt[0:3];
      end
    end
  end

  // Checks of the write behaviour
  // Typed so that the two-bit opcode is not cut to one bit
  sequence s_take(fsw_op_t k);
    accept && (req_op == k);
  endsequence

  sequence s_done_once;
    done_r ##1 !done_r;
  endsequence

  property p_f0_direct;
    @(posedge clk) disable iff (reset)
    s_take(FSW_OP_FIELD_IMM) and (target_field_index == '0) |=>
      status_r[BIT_FX] == $past(immediate_nibble[0]) &&
      status_r[BIT_OX] == $past(immediate_nibble[3]);
  endproperty
  a_f0_direct: assert property (p_f0_direct)
    else $error("field 0 immediate did not load summary and overflow");

  property p_f0_no_sticky;
    @(posedge clk) disable iff (reset)
    s_take(FSW_OP_FIELD_MASK) and field_mask[0] &&
      !source_fp_register[SRC_LO] && !exc_valid |=> !status_r[BIT_FX];
  endproperty
  a_f0_no_sticky: assert property (p_f0_no_sticky)
    else $error("field 0 write set the exception summary");

  property p_sticky;
    @(posedge clk) disable iff (reset)
    exc_valid && !accept && |(exc_bits & EXC_MASK & ~status_r) |=>
      status_r[BIT_FX];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("rising exception did not set the exception summary");

  property p_summaries;
    @(posedge clk) disable iff (reset)
    $past(done_r) || done_r |->
      status_r[BIT_VX] == vx_of(status_r) &&
      status_r[BIT_FEX] == fex_of(status_r);
  endproperty
  a_summaries: assert property (p_summaries)
    else $error("summary bits disagree with their sources");

  property p_mask_copy;
    @(posedge clk) disable iff (reset)
    s_take(FSW_OP_FIELD_MASK) and field_mask[7] |=>
      status_r[28:31] == $past(source_fp_register[60:63]);
  endproperty
  a_mask_copy: assert property (p_mask_copy)
    else $error("selected field not copied from source low word");

  property p_mask_keep;
    @(posedge clk) disable iff (reset)
    s_take(FSW_OP_FIELD_MASK) and !field_mask[6] && !exc_valid |=>
      status_r[24:27] == $past(status_r[24:27]);
  endproperty
  a_mask_keep: assert property (p_mask_keep)
    else $error("unselected field changed");

  property p_latency;
    @(posedge clk) disable iff (reset)
    accept ##1 !accept |-> s_done_once;
  endproperty
  a_latency: assert property (p_latency)
    else $error("completion not exactly one cycle after acceptance");

  property p_clr;
    @(posedge clk) disable iff (reset)
    s_take(FSW_OP_BIT_CLR) and (target_bit_index > IDX_W'(BIT_OX)) |=>
      !status_r[$past(target_bit_index)];
  endproperty
  a_clr: assert property (p_clr)
    else $error("bit clear left the bit set");

  property p_set;
    @(posedge clk) disable iff (reset)
    s_take(FSW_OP_BIT_SET) and !is_derived(target_bit_index) |=>
      status_r[$past(target_bit_index)];
  endproperty
  a_set: assert property (p_set)
    else $error("bit set left the bit clear");

  property p_record;
    @(posedge clk) disable iff (reset)
    accept |=> (cr_upd_r == $past(req_record)) &&
      (!cr_upd_r || cr_nib_r == status_r[0:3]);
  endproperty
  a_record: assert property (p_record)
    else $error("condition field update wrong");

  property p_no_record;
    @(posedge clk) disable iff (reset)
    !accept |=> !cr_upd_r && $stable(cr_nib_r);
  endproperty
  a_no_record: assert property (p_no_record)
    else $error("condition field changed without a record write");

  property p_imm_field;
    @(posedge clk) disable iff (reset)
    s_take(FSW_OP_FIELD_IMM) and (target_field_index == 3'h7) |=>
      status_r[28:31] == $past(immediate_nibble) &&
      status_r[20:23] == $past(status_r[20:23]);
  endproperty
  a_imm_field: assert property (p_imm_field)
    else $error("immediate nibble misplaced");

  property p_sync;
    @(posedge clk) disable iff (reset)
    req_valid && !fp_drained |-> (fp_issue_hold && !req_ready) ##1 !done_r;
  endproperty
  a_sync: assert property (p_sync)
    else $error("status write executed before the FP pipe drained");

endmodule : fsw_writer

// ==== src/fsw_pkg.sv ====
/*
  Shared constants and types for the floating-point status field writer:
  field geometry, summary and exception bit positions, reset value, opcodes.
  Assumes big-endian bit numbering: bit 0 is the most significant bit.
*/
package fsw_pkg;

  // Geometry of the status register and of the source operand
  localparam int STAT_W     = 32;
  localparam int FIELD_W    = 4;
  localparam int NUM_FIELDS = 8;
  localparam int SRC_W      = 64;
  localparam int SRC_LO     = 32;
  localparam int IDX_W      = 5;
  localparam int FLD_IDX_W  = 3;

  // Fixed execution latency in clock cycles, whatever the mask holds
  localparam int EXEC_LATENCY = 1;

  // Summary and exception bit positions
  localparam int BIT_FX  = 0;
  localparam int BIT_FEX = 1;
  localparam int BIT_VX  = 2;
  localparam int BIT_OX  = 3;
  localparam int BIT_UX  = 4;
  localparam int BIT_ZX  = 5;
  localparam int BIT_XX  = 6;
  localparam int BIT_VE  = 24;
  localparam int BIT_OE  = 25;
  localparam int BIT_UE  = 26;
  localparam int BIT_ZE  = 27;
  localparam int BIT_XE  = 28;

  // Reset value and bit classes
  localparam logic [0:31] STAT_RESET  = 32'h0000_0000;
  localparam logic [0:31] EXC_MASK    = 32'h1FF8_0700;
  localparam logic [0:31] VX_CAUSES   = 32'h01F8_0700;
  localparam logic [0:3]  NIBBLE_ZERO = 4'h0;

  // Status-write instruction kinds
  typedef enum logic [1:0] {
    FSW_OP_FIELD_IMM,
    FSW_OP_FIELD_MASK,
    FSW_OP_BIT_CLR,
    FSW_OP_BIT_SET
  } fsw_op_t;

endpackage : fsw_pkg

// ==== verification/fsw_issue_model.sv ====
/*
  Issue-side partner model: reports when earlier FP work has drained.
  Assumes the bench pulses start with a drain time in lat cycles.
*/
module fsw_issue_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       start,
  input  wire logic [3:0] lat,
  output logic            fp_drained
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] busy_r;

  // Earlier FP work still in flight; can be slow or prompt
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_r <= 4'h0;
    end else if (start) begin
      busy_r <= lat;
    end else if (busy_r != 4'h0) begin
      busy_r <= busy_r - 4'h1;
    end
  end

  assign fp_drained = (busy_r == 4'h0); // Drain done only when count empty
endmodule : fsw_issue_model

// ==== verification/test_fsw_writer.sv ====
/*
  Self-checking bench for the status field writer with a scoreboard queue.
  Assumes the issue model drives fp_drained; inputs change 2 ns after edges.
*/
module test_fsw_writer;
  import fsw_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {logic [0:31] st; logic rec; logic [0:3] cf; int at;} fsw_note_t;
  logic clk, reset, req_valid, req_ready, req_record, fp_drained, fp_issue_hold;
  logic exc_valid, done, cr_update, start;
  fsw_op_t req_op;
  logic [FLD_IDX_W-1:0] target_field_index;
  logic [0:3] immediate_nibble, condition_register_field, cond_m;
  logic [0:7] field_mask;
  logic [0:SRC_W-1] source_fp_register;
  logic [IDX_W-1:0] target_bit_index;
  logic [0:STAT_W-1] exc_bits, fp_status_control, model;
  logic [3:0] lat;
  int err_count, total_checks, cyc;
  fsw_note_t q[$];
  fsw_note_t note;
  logic [0:3] nib [4] = '{4'h0, 4'h1, 4'h6, 4'hF};

  fsw_writer dut (.clk, .reset, .req_valid, .req_ready, .req_op, .req_record,
    .target_field_index, .immediate_nibble, .field_mask, .source_fp_register,
    .target_bit_index, .fp_drained, .fp_issue_hold, .exc_valid, .exc_bits, .done,
    .fp_status_control, .cr_update, .condition_register_field);
  fsw_issue_model issue_m (.clk, .reset, .start, .lat, .fp_drained);

  // Reference status update; exc selects an exception report
  function automatic logic [0:31] nxt(logic [0:31] s, logic exc);
    logic [0:31] n;
    logic f0;
    n = s | (exc ? (exc_bits & EXC_MASK) : 32'h0000_0000);
    f0 = 1'b0;
    if (!exc) begin
      case (req_op)
        FSW_OP_FIELD_IMM: begin
          n[4*target_field_index +: 4] = immediate_nibble;
          f0 = (target_field_index == 3'h0);
        end
        FSW_OP_FIELD_MASK: begin
          for (int i = 0; i < NUM_FIELDS; i++)
            if (field_mask[i]) n[4*i +: 4] = source_fp_register[SRC_LO+4*i +: 4];
          f0 = field_mask[0];
        end
        default: if (target_bit_index != 5'h1 && target_bit_index != 5'h2)
          n[target_bit_index] = (req_op == FSW_OP_BIT_SET);
      endcase
    end
    if (!f0) n[BIT_FX] = n[BIT_FX] | (|(n & ~s & EXC_MASK));
    n[BIT_VX] = |(n & VX_CAUSES);
    n[BIT_FEX] = (n[BIT_OX] & n[BIT_OE]) | (n[BIT_UX] & n[BIT_UE]) | (n[BIT_ZX] & n[BIT_ZE])
      | (n[BIT_XX] & n[BIT_XE]) | (n[BIT_VX] & n[BIT_VE]);
    return n;
  endfunction : nxt

  task automatic chk(logic [0:31] seen, logic [0:31] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  // Hold the request until drained, then note the expected answer
  task automatic issue(fsw_op_t op, logic rec);
    int n;
    req_op = op;
    req_record = rec;
    req_valid = 1'b1;
    n = 0;
    while (fp_drained !== 1'b1 && n < 40) begin
      chk(req_ready, 1'b0);
      chk(fp_issue_hold, 1'b1);
      @(posedge clk);
      #2;
      n++;
    end
    chk(req_ready, 1'b1);
    chk(fp_issue_hold, 1'b1);
    @(posedge clk);
    #2;
    model = nxt(model, 1'b0);
    if (rec) cond_m = model[0:3];
    // Count after the accept edge; done must show in this same cycle
    q.push_back('{model, rec, cond_m, cyc});
  endtask : issue

  task automatic report(logic [0:31] b);
    exc_bits = b;
    exc_valid = 1'b1;
    @(posedge clk);
    #2;
    exc_valid = 1'b0;
    model = nxt(model, 1'b1);
    chk(fp_status_control, model);
  endtask : report

  task summarize;
    $display("errors %0d checks %0d", err_count, total_checks);
    if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  // Clock and cycle count for latency notes
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  // Scoreboard: every done must match the oldest note, one cycle late
  always @(negedge clk) if (done === 1'b1) begin
    if (q.size() == 0) chk(done, 1'b0);
    else begin
      note = q.pop_front();
      chk(fp_status_control, note.st);
      chk(cr_update, note.rec);
      chk(condition_register_field, note.cf);
      chk(cyc, note.at);
    end
  end

  // Watchdog well beyond the roughly 120 cycles the run needs
  initial begin
    #200000;
    err_count++;
    summarize;
  end

  initial begin
    {reset, req_valid, req_record, exc_valid, start} = 5'h10;
    {target_field_index, immediate_nibble, field_mask, target_bit_index} = '0;
    {source_fp_register, exc_bits, lat, cyc} = '0;
    req_op = FSW_OP_FIELD_IMM;
    model = STAT_RESET;
    cond_m = 4'h0;
    void'($urandom(34587));
    repeat (4) @(posedge clk);
    #2;
    reset = 1'b0;
    chk(fp_status_control, STAT_RESET);
    // Immediate write to each field, back to back
    for (int f = 0; f < 8; f++) begin
      target_field_index = f[2:0];
      immediate_nibble = 4'($urandom);
      issue(FSW_OP_FIELD_IMM, f[0]);
    end
    // Field 0 corner nibbles: overflow rising, summary bits in source
    target_field_index = 3'h0;
    foreach (nib[k]) begin
      immediate_nibble = nib[k];
      issue(FSW_OP_FIELD_IMM, 1'b1);
    end
    // Masked writes: all, field 7 only, random masks
    for (int k = 0; k < 16; k++) begin
      field_mask = (k == 0) ? 8'hFF : (k == 1) ? 8'h01 : 8'($urandom);
      source_fp_register = {$urandom, $urandom};
      issue(FSW_OP_FIELD_MASK, k[1]);
    end
    // Set then clear every bit, summaries included
    for (int b = 0; b < 32; b++) begin
      target_bit_index = b[4:0];
      issue(FSW_OP_BIT_SET, b[0]);
      issue(FSW_OP_BIT_CLR, 1'b0);
    end
    req_valid = 1'b0;
    // Slow drain: request must wait, later issue held
    start = 1'b1;
    lat = 4'($urandom_range(9, 3));
    @(posedge clk);
    #2;
    start = 1'b0;
    issue(FSW_OP_BIT_SET, 1'b1);
    // Exception reports after clearing the summary
    repeat (4) begin
      target_bit_index = 5'h0;
      issue(FSW_OP_BIT_CLR, 1'b1);
      req_valid = 1'b0;
      report($urandom);
    end
    repeat (3) @(posedge clk);
    chk(q.size(), 0);
    summarize;
  end
endmodule : test_fsw_writer
